// ===== hpsic_slot_ctl.sv
// slot control register: indicators, hot-plug interrupt enables
`timescale 1ns/1ps
module hpsic_slot_ctl #(
    parameter int BLINK_HALF_CYCLES = hpsic_pkg::BLINK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wdata,
    input wire logic msg_irq_enable,
    input wire logic presence_change_flag,
    output logic [15:0] cfg_rdata,
    output logic power_led_pin,
    output logic attention_led_pin,
    output logic pwr_msg_valid,
    output logic [1:0] pwr_msg_state,
    output logic atn_msg_valid,
    output logic [1:0] atn_msg_state,
    output logic cmd_done,
    output logic irq_req,
    output logic pme_req
);
    logic [15:0] store_reg;
    logic [15:0] rdata_reg;
    logic cmd_done_reg;
    logic irq_reg;
    logic pme_reg;
    logic pres_d_reg;
    logic [hpsic_pkg::BLINK_CNT_W-1:0] blink_cnt_reg;
    logic blink_reg;
    wire logic [1:0] power_indicator_field;
    wire logic [1:0] attention_indicator_field;
    wire logic [15:0] cur_value;
    wire logic ctl_change;
    wire logic hotplug_irq_enable;
    wire logic cmd_done_irq_enable;
    wire logic presence_change_enable;
    wire logic pres_rise;
    wire logic irq_next;
    wire logic blink_wrap;

    localparam logic [hpsic_pkg::BLINK_CNT_W-1:0] BLINK_LAST =
        hpsic_pkg::BLINK_CNT_W'(BLINK_HALF_CYCLES - 1);

    // =====================================================
    // blink timebase shared by both indicators
    assign blink_wrap = (blink_cnt_reg == BLINK_LAST);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
        end else begin
            blink_cnt_reg <= blink_wrap ? '0 : blink_cnt_reg + 1'b1;
            blink_reg <= blink_wrap ? ~blink_reg : blink_reg;
        end
    end

    // =====================================================
    // indicator channels
    hpsic_indicator #(
        .RESET_VAL(hpsic_pkg::SLOT_CTL_RESET[hpsic_pkg::PWR_IND_LSB +: 2])
    ) u_pwr (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_en(cfg_wr),
        .wr_field(cfg_wdata[hpsic_pkg::PWR_IND_LSB +: 2]),
        .blink_phase(blink_reg),
        .field_out(power_indicator_field),
        .msg_valid(pwr_msg_valid),
        .msg_state(pwr_msg_state),
        .led(power_led_pin)
    );

    hpsic_indicator #(
        .RESET_VAL(hpsic_pkg::SLOT_CTL_RESET[hpsic_pkg::ATN_IND_LSB +: 2])
    ) u_atn (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_en(cfg_wr),
        .wr_field(cfg_wdata[hpsic_pkg::ATN_IND_LSB +: 2]),
        .blink_phase(blink_reg),
        .field_out(attention_indicator_field),
        .msg_valid(atn_msg_valid),
        .msg_state(atn_msg_state),
        .led(attention_led_pin)
    );

    // =====================================================
    // register image, enables and command detect
    assign cur_value = (store_reg & hpsic_pkg::SLOT_CTL_STORE_MASK)
                     | {6'h00, power_indicator_field, attention_indicator_field, 6'h00};
    assign hotplug_irq_enable = store_reg[hpsic_pkg::HP_IRQ_EN_BIT];
    assign cmd_done_irq_enable = store_reg[hpsic_pkg::CMD_IRQ_EN_BIT];
    assign presence_change_enable = store_reg[hpsic_pkg::PRES_EN_BIT];
    // unchanged indicator bits fall out of the compare, so no command
    assign ctl_change = cfg_wr
        && ((cfg_wdata & hpsic_pkg::SLOT_CTL_STORE_MASK) != cur_value);
    assign pres_rise = presence_change_flag && !pres_d_reg;
    // every path goes through the hot-plug gate
    assign irq_next = hotplug_irq_enable && msg_irq_enable
        && ((cmd_done_irq_enable && cmd_done_reg) || (presence_change_enable && pres_rise));

    // control field storage, indicator bits included; the channels hold their own copy
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            store_reg <= hpsic_pkg::SLOT_CTL_RESET & hpsic_pkg::SLOT_CTL_STORE_MASK;
        end else if (cfg_wr) begin
            store_reg <= cfg_wdata & hpsic_pkg::SLOT_CTL_STORE_MASK;
        end
    end

    // readback shows a write two clocks after it; interlock bit always reads zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= hpsic_pkg::SLOT_CTL_RESET;
        end else begin
            rdata_reg <= cur_value;
        end
    end

    // command completes the clock after it is taken; events then gated out
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cmd_done_reg <= 1'b0;
            irq_reg <= 1'b0;
            pme_reg <= 1'b0;
            pres_d_reg <= 1'b0;
        end else begin
            cmd_done_reg <= ctl_change;
            irq_reg <= irq_next;
            pme_reg <= presence_change_enable && pres_rise;
            pres_d_reg <= presence_change_flag;
        end
    end

    assign cfg_rdata = rdata_reg;
    assign cmd_done = cmd_done_reg;
    assign irq_req = irq_reg;
    assign pme_req = pme_reg;

    // =====================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // a write that moves the field away from what it holds
    sequence pwr_change_s;
        cfg_wr && (cfg_wdata[hpsic_pkg::PWR_IND_LSB +: 2] != power_indicator_field);
    endsequence
    sequence atn_change_s;
        cfg_wr && (cfg_wdata[hpsic_pkg::ATN_IND_LSB +: 2] != attention_indicator_field);
    endsequence
    // field steady for two clocks, so the led, one clock behind, has caught up
    sequence pwr_on_held_s;
        (power_indicator_field == hpsic_pkg::IND_ON)
            ##1 (power_indicator_field == hpsic_pkg::IND_ON);
    endsequence
    sequence atn_off_held_s;
        (attention_indicator_field == hpsic_pkg::IND_OFF)
            ##1 (attention_indicator_field == hpsic_pkg::IND_OFF);
    endsequence
    // a taken command, then all three interrupt gates open as it completes
    sequence cmd_enabled_s;
        ctl_change ##1 (hotplug_irq_enable && msg_irq_enable && cmd_done_irq_enable);
    endsequence

    // indicator messages: one per change, none otherwise
    AST_PWR_MSG: assert property (
        pwr_change_s |=> pwr_msg_valid
            && (pwr_msg_state == $past(cfg_wdata[hpsic_pkg::PWR_IND_LSB +: 2])))
        else $error("power change gave no message");
    AST_ATN_MSG: assert property (
        atn_change_s |=> atn_msg_valid
            && (atn_msg_state == $past(cfg_wdata[hpsic_pkg::ATN_IND_LSB +: 2])))
        else $error("attention change gave no message");
    AST_NO_MSG: assert property (
        !(cfg_wr && (cfg_wdata[hpsic_pkg::PWR_IND_LSB +: 2] != power_indicator_field))
            |=> !pwr_msg_valid)
        else $error("message without power change");
    AST_ATN_NO_MSG: assert property (
        !(cfg_wr && (cfg_wdata[hpsic_pkg::ATN_IND_LSB +: 2] != attention_indicator_field))
            |=> !atn_msg_valid)
        else $error("message without attention change");

    // readback shows the written fields two clocks after the write
    AST_PWR_RB: assert property (
        cfg_wr |=> ##1 cfg_rdata[hpsic_pkg::PWR_IND_LSB +: 2]
            == $past(cfg_wdata[hpsic_pkg::PWR_IND_LSB +: 2], 2))
        else $error("power field readback wrong");
    AST_ATN_RB: assert property (
        cfg_wr |=> ##1 cfg_rdata[hpsic_pkg::ATN_IND_LSB +: 2]
            == $past(cfg_wdata[hpsic_pkg::ATN_IND_LSB +: 2], 2))
        else $error("attention field readback wrong");

    // steady led levels
    AST_POWER_LED_PIN: assert property (pwr_on_held_s |-> power_led_pin)
        else $error("power led not lit");
    AST_ATTENTION_LED_PIN: assert property (atn_off_held_s |-> !attention_led_pin)
        else $error("attention led not dark");

    // interrupt gating and command completion
    AST_HP_GATE: assert property (!hotplug_irq_enable |=> !irq_req)
        else $error("interrupt while hot-plug gate closed");
    AST_CMD_IRQ: assert property (cmd_enabled_s |=> irq_req)
        else $error("command done interrupt missing");
    AST_MSG_GATE: assert property (!msg_irq_enable |=> !irq_req)
        else $error("interrupt with message enable clear");
    AST_CMD: assert property (ctl_change |=> cmd_done)
        else $error("command not completed");

    // presence events: one per rise of the flag
    AST_PRES: assert property (presence_change_enable && pres_rise |=> pme_req)
        else $error("presence change lost");
    AST_PRES_ONCE: assert property (presence_change_flag && pres_d_reg |=> !pme_req)
        else $error("power event from a held presence flag");
endmodule

// ===== hpsic_pkg.sv
// constants for the hot-plug slot indicator control block
package hpsic_pkg;
    // =====================================================
    // register placement and layout
    localparam logic [7:0] SLOT_CTL_OFFSET = 8'ha8;
    localparam logic [15:0] SLOT_CTL_RESET = 16'h07c0;
    localparam int PWR_IND_LSB = 8;
    localparam int ATN_IND_LSB = 6;
    localparam int HP_IRQ_EN_BIT = 5;
    localparam int CMD_IRQ_EN_BIT = 4;
    localparam int PRES_EN_BIT = 3;
    localparam int INTERLOCK_BIT = 11;
    // bits that hold state and count as control fields
    localparam logic [15:0] SLOT_CTL_STORE_MASK = 16'h17ff;
    // =====================================================
    // indicator encodings
    localparam logic [1:0] IND_RSVD = 2'h0;
    localparam logic [1:0] IND_ON = 2'h1;
    localparam logic [1:0] IND_BLINK = 2'h2;
    localparam logic [1:0] IND_OFF = 2'h3;
    // =====================================================
    // timing: 40 MHz core clock, blink half period
    localparam int CLK_PERIOD_NS = 25;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
    localparam int BLINK_CNT_W = 25;
endpackage

// ===== hpsic_indicator.sv
// one indicator channel: field storage, change message and led drive
`timescale 1ns/1ps
module hpsic_indicator #(
    parameter logic [1:0] RESET_VAL = 2'h3
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [1:0] wr_field,
    input wire logic blink_phase,
    output logic [1:0] field_out,
    output logic msg_valid,
    output logic [1:0] msg_state,
    output logic led
);
    logic [1:0] field_reg;
    logic msg_reg;
    logic [1:0] msg_state_reg;
    logic led_reg;
    wire logic changed;
    wire logic led_next;

    // =====================================================
    // change detect and led decode
    assign changed = wr_en && (wr_field != field_reg);
    // reserved code leaves the led dark rather than guessing
    assign led_next = (field_reg == hpsic_pkg::IND_ON) ? 1'b1 :
                      (field_reg == hpsic_pkg::IND_BLINK) ? blink_phase : 1'b0;

    // field storage and message pulse on change only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            field_reg <= RESET_VAL;
            msg_reg <= 1'b0;
            msg_state_reg <= RESET_VAL;
            led_reg <= 1'b0;
        end else begin
            if (wr_en) begin
                field_reg <= wr_field;
            end
            msg_reg <= changed;
            if (changed) begin
                msg_state_reg <= wr_field;
            end
            led_reg <= led_next;
        end
    end

    assign field_out = field_reg;
    assign msg_valid = msg_reg;
    assign msg_state = msg_state_reg;
    assign led = led_reg;
endmodule

// ===== hpsic_far_end.sv
// far-side model: downstream message sink for the two indicators
`timescale 1ns/1ps
module hpsic_far_end (
    input wire logic clk_sys,
    input wire logic pwr_msg_valid,
    input wire logic [1:0] pwr_msg_state,
    input wire logic atn_msg_valid,
    input wire logic [1:0] atn_msg_state
);
    int n_pwr = 0;
    int n_atn = 0;
    logic [1:0] pwr_seen = 2'h3;
    logic [1:0] atn_seen = 2'h3;
    // =====================================================
    // message intake
    // state is taken with the pulse, as it may move right after
    always @(posedge clk_sys) begin
        if (pwr_msg_valid === 1'b1) begin
            n_pwr <= n_pwr + 1;
            pwr_seen <= pwr_msg_state;
        end
        if (atn_msg_valid === 1'b1) begin
            n_atn <= n_atn + 1;
            atn_seen <= atn_msg_state;
        end
    end
endmodule

// ===== testbench.sv
// self-checking bench for the slot control indicator block
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic cfg_wr = 1'b0;
    logic [15:0] cfg_wdata = 16'h0000;
    logic msg_irq_enable = 1'b0;
    logic presence_change_flag = 1'b0;
    logic [15:0] cfg_rdata;
    logic power_led_pin, attention_led_pin, pwr_msg_valid, atn_msg_valid;
    logic [1:0] pwr_msg_state, atn_msg_state;
    logic cmd_done, irq_req, pme_req;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 32'h97f9;
    int exp_pwr = 0;
    int exp_atn = 0;
    logic [15:0] cur = hpsic_pkg::SLOT_CTL_RESET;
    // =====================================================
    // clock, design and far side
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // short blink period keeps the toggle check cheap
    hpsic_slot_ctl #(.BLINK_HALF_CYCLES(4)) dut (.clk_sys(clk_sys), .rstn(rstn),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .msg_irq_enable(msg_irq_enable),
        .presence_change_flag(presence_change_flag), .cfg_rdata(cfg_rdata),
        .power_led_pin(power_led_pin), .attention_led_pin(attention_led_pin),
        .pwr_msg_valid(pwr_msg_valid), .pwr_msg_state(pwr_msg_state),
        .atn_msg_valid(atn_msg_valid), .atn_msg_state(atn_msg_state),
        .cmd_done(cmd_done), .irq_req(irq_req), .pme_req(pme_req));
    hpsic_far_end far (.clk_sys(clk_sys), .pwr_msg_valid(pwr_msg_valid),
        .pwr_msg_state(pwr_msg_state), .atn_msg_valid(atn_msg_valid),
        .atn_msg_state(atn_msg_state));
    // =====================================================
    // helpers
    function automatic logic led_of(input logic [1:0] f);
        return f == hpsic_pkg::IND_ON;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one register write, entered and left at a falling edge
    task automatic wr(input logic [15:0] d);
        logic [15:0] nv;
        logic pc, ac, ch;
        nv = d & hpsic_pkg::SLOT_CTL_STORE_MASK;
        pc = nv[9:8] != cur[9:8];
        ac = nv[7:6] != cur[7:6];
        ch = nv != cur;
        exp_pwr += int'(pc);
        exp_atn += int'(ac);
        cfg_wr = 1'b1;
        cfg_wdata = d;
        @(negedge clk_sys);
        // pulses stand only in the cycle after the taking edge
        cfg_wr = 1'b0;
        chk("pwr_msg_valid", 16'(pc), 16'(pwr_msg_valid));
        chk("atn_msg_valid", 16'(ac), 16'(atn_msg_valid));
        chk("cmd_done", 16'(ch), 16'(cmd_done));
        if (pc) chk("pwr_msg_state", 16'(nv[9:8]), 16'(pwr_msg_state));
        if (ac) chk("atn_msg_state", 16'(nv[7:6]), 16'(atn_msg_state));
        @(negedge clk_sys);
        cur = nv;
        chk("cfg_rdata", nv, cfg_rdata);
        chk("irq_req", 16'(ch & nv[5] & nv[4] & msg_irq_enable), 16'(irq_req));
        if (nv[9:8] != hpsic_pkg::IND_BLINK) begin
            chk("power_led_pin", 16'(led_of(nv[9:8])), 16'(power_led_pin));
        end
        if (nv[7:6] != hpsic_pkg::IND_BLINK) begin
            chk("attention_led_pin", 16'(led_of(nv[7:6])), 16'(attention_led_pin));
        end
    endtask
    // blinking leds must toggle twice in eight cycles, steady ones never
    task automatic blink_chk();
        int tp, ta;
        logic lp, la;
        tp = 0;
        ta = 0;
        repeat (8) begin
            lp = power_led_pin;
            la = attention_led_pin;
            @(negedge clk_sys);
            tp += int'(power_led_pin !== lp);
            ta += int'(attention_led_pin !== la);
        end
        chk("pwr_toggles", (cur[9:8] == hpsic_pkg::IND_BLINK) ? 16'h2 : 16'h0, 16'(tp));
        chk("atn_toggles", (cur[7:6] == hpsic_pkg::IND_BLINK) ? 16'h2 : 16'h0, 16'(ta));
    endtask
    // presence change: one event per rise, however long the flag stays high
    task automatic pres();
        presence_change_flag = 1'b1;
        // event pulses stand only in the cycle after the rise is seen
        @(negedge clk_sys);
        chk("pme_req", 16'(cur[3]), 16'(pme_req));
        chk("irq_pres", 16'(cur[3] & cur[5] & msg_irq_enable), 16'(irq_req));
        @(negedge clk_sys);
        chk("pme_held", 16'h0, 16'(pme_req));
        presence_change_flag = 1'b0;
        @(negedge clk_sys);
    endtask
    // =====================================================
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end
    // =====================================================
    // main sequence
    initial begin
        repeat (6) @(negedge clk_sys);
        rstn = 1'b1;
        chk("cfg_rdata_rst", hpsic_pkg::SLOT_CTL_RESET, cfg_rdata);
        wr(16'hffff);
        wr(16'hffff);
        msg_irq_enable = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr({6'h00, 2'(i), 2'(3 - i), 6'h38});
            blink_chk();
            pres();
        end
        wr(16'h0008);
        pres();
        for (int i = 0; i < 30; i++) begin
            msg_irq_enable = 1'($random(seed));
            wr(16'($random(seed)));
            if (i % 5 == 0) pres();
        end
        chk("far_pwr_count", 16'(exp_pwr), 16'(far.n_pwr));
        chk("far_atn_count", 16'(exp_atn), 16'(far.n_atn));
        chk("far_pwr_state", 16'(cur[9:8]), 16'(far.pwr_seen));
        chk("far_atn_state", 16'(cur[7:6]), 16'(far.atn_seen));
        stop_test();
    end
endmodule
